//--- swr_cpu_model.sv
module swr_cpu_model (
	input wire logic ref_clk,
	input wire logic rstIn,
	input wire logic kickOn,
	input wire logic floatPin,
	output logic kick_in,
	output logic kick_driven
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned gapQ = 0;
	logic kickLvl = 1'b0;
	// kick well inside period
	// undriven pin shows no edges, so a live watchdog would run out
	always @(posedge ref_clk) begin
		gapQ <= (gapQ == 19) ? 0 : gapQ + 1;
		if (kickOn && !floatPin && !rstIn && gapQ == 0)
			kickLvl <= #1 ~kickLvl;
	end
	assign kick_in = kickLvl;
	assign kick_driven = ~floatPin;
endmodule : swr_cpu_model

//--- swr_debounce.sv
module swr_debounce
	import swr_pkg::*;
#(
	parameter longint unsigned STABLE_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic rawIn,
	output logic cleanOut
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic clean_q;
	logic clean_d;

	// level must hold for the full window before the output follows
	always_comb begin
		cnt_d = '0;
		clean_d = clean_q;
		if (rawIn != clean_q) begin
			if (cnt_q >= CNT_W'(STABLE_CYCLES - 1)) begin
				clean_d = rawIn;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_q <= '0;
			clean_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			clean_q <= clean_d;
		end
	end

	assign cleanOut = clean_q;
endmodule : swr_debounce

//--- swr_pkg.sv
package swr_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// times in their own units
	localparam int unsigned HOLD_TIME_MS = 200;
	localparam int unsigned WDOG_TIME_MS = 1600;
	localparam int unsigned DEBOUNCE_TIME_US = 1000;
	localparam longint unsigned HOLD_CYCLES = (longint'(HOLD_TIME_MS) * CLK_HZ) / 1000;
	localparam longint unsigned WDOG_CYCLES = (longint'(WDOG_TIME_MS) * CLK_HZ) / 1000;
	localparam longint unsigned DEBOUNCE_CYCLES = (longint'(DEBOUNCE_TIME_US) * CLK_HZ) / 1000000;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned SYNC_STAGES = 2;
	// reset values
	localparam logic RESET_ACTIVE_RST = 1'b1;
	typedef enum logic [1:0] {SWR_HOLD, SWR_ARMED, SWR_RUN} swr_state_e;
endpackage : swr_pkg

//--- swr_supervisor.sv
// Operation
// - manual reset low generates reset
// - manual reset active low, debounced
// - undriven manual reset reads deasserted
// - reset asserted at power-up
// - reset on supply below trip level
// - aux fail output follows comparator
// - watchdog expiry drives timeout output low
// - any kick edge or manual reset clears
// - floating kick input disables watchdog
// - active-low reset is open drain
// - reset held 200ms after cause ends
// - expiry alone never asserts reset
// - active-high reset complements active-low
// - timeout output stays low until cleared
// - timeout output low while supply low
// - timeout output releases without stretch
// - hold time extendable by adjust input
module swr_supervisor
	import swr_pkg::*;
#(
	parameter longint unsigned HOLD_COUNT = HOLD_CYCLES,
	parameter longint unsigned WDOG_COUNT = WDOG_CYCLES,
	parameter longint unsigned DEBOUNCE_COUNT = DEBOUNCE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic manual_reset_in_n,
	input wire logic supply_low,
	input wire logic aux_monitor_in,
	input wire logic kick_in,
	input wire logic kick_driven,
	input wire logic [CNT_W-1:0] hold_delay_adjust,
	output logic aux_fail_out,
	output logic rstOut_n_o,
	output logic rstOut_n_oe,
	output logic rstOut,
	output logic timeout_flag_out_n
);
	import swr_pkg::*;

	logic mrSync;
	logic mrClean;
	logic supplyLowSync;
	logic auxSync;
	logic kickSync;
	logic kickDrivenSync;

	// idle high, an undriven pin reads released
	swr_sync #(.RESET_VAL(1'b1)) uMrSync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(manual_reset_in_n),
		.syncOut(mrSync)
	);
	swr_sync #(.RESET_VAL(1'b1)) uSupSync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(supply_low),
		.syncOut(supplyLowSync)
	);
	swr_sync #(.RESET_VAL(1'b0)) uAuxSync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(aux_monitor_in),
		.syncOut(auxSync)
	);
	swr_sync #(.RESET_VAL(1'b0)) uKickSync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(kick_in),
		.syncOut(kickSync)
	);
	swr_sync #(.RESET_VAL(1'b0)) uKickDrvSync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(kick_driven),
		.syncOut(kickDrivenSync)
	);

	swr_debounce #(.STABLE_CYCLES(DEBOUNCE_COUNT)) uMrDeb (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.rawIn(mrSync),
		.cleanOut(mrClean)
	);

	// ---------------- reset generator ----------------
	logic [CNT_W-1:0] holdCnt_q;
	logic [CNT_W-1:0] holdCnt_d;
	logic rstAct_q;
	logic rstAct_d;
	logic [CNT_W-1:0] holdTarget;
	logic resetCause;

	// adjust input lengthens hold, never shortens
	always_comb begin
		holdTarget = CNT_W'(HOLD_COUNT);
		if (hold_delay_adjust > CNT_W'(HOLD_COUNT)) begin
			holdTarget = hold_delay_adjust;
		end
	end

	// causes of reset; watchdog deliberately absent
	assign resetCause = !mrClean || supplyLowSync;

	always_comb begin
		holdCnt_d = holdCnt_q;
		rstAct_d = rstAct_q;
		if (resetCause) begin
			holdCnt_d = '0;
			rstAct_d = 1'b1;
		end else if (rstAct_q) begin
			if (holdCnt_q >= holdTarget - 1'b1) begin
				rstAct_d = 1'b0;
				holdCnt_d = '0;
			end else begin
				holdCnt_d = holdCnt_q + 1'b1;
			end
		end
	end

	// power-up starts in reset with hold pending
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			holdCnt_q <= '0;
			rstAct_q <= RESET_ACTIVE_RST;
		end else begin
			holdCnt_q <= holdCnt_d;
			rstAct_q <= rstAct_d;
		end
	end

	assign rstOut_n_o = 1'b0;
	assign rstOut_n_oe = rstAct_q;
	assign rstOut = rstAct_q;

	// ---------------- power-fail ----------------
	logic auxFail_q;
	logic auxFail_d;
	always_comb begin
		auxFail_d = auxSync;
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			auxFail_q <= 1'b0;
		end else begin
			auxFail_q <= auxFail_d;
		end
	end
	assign aux_fail_out = auxFail_q;

	// ---------------- watchdog ----------------
	logic [CNT_W-1:0] wdCnt_q;
	logic [CNT_W-1:0] wdCnt_d;
	logic kickPrev_q;
	logic kickPrev_d;
	logic expired_q;
	logic expired_d;
	swr_state_e wdState_q;
	swr_state_e wdState_d;
	logic kickEdge;
	logic wdClear;

	assign kickEdge = kickSync != kickPrev_q;
	// both kick edges and manual reset clear
	assign wdClear = kickEdge || !mrClean;

	always_comb begin
		wdCnt_d = wdCnt_q;
		expired_d = expired_q;
		wdState_d = wdState_q;
		kickPrev_d = kickSync;
		unique case (wdState_q)
			SWR_HOLD: begin
				wdCnt_d = '0;
				expired_d = 1'b0;
				if (!supplyLowSync) begin
					wdState_d = SWR_ARMED;
				end
			end
			SWR_ARMED: begin
				wdCnt_d = '0;
				expired_d = 1'b0;
				if (kickDrivenSync) begin
					wdState_d = SWR_RUN;
				end
			end
			SWR_RUN: begin
				if (!kickDrivenSync) begin
					wdState_d = SWR_ARMED;
					wdCnt_d = '0;
					expired_d = 1'b0;
				end else if (wdClear) begin
					wdCnt_d = '0;
					expired_d = 1'b0;
				end else if (wdCnt_q >= CNT_W'(WDOG_COUNT - 1)) begin
					expired_d = 1'b1;
				end else begin
					wdCnt_d = wdCnt_q + 1'b1;
				end
			end
		endcase
		// supply low overrides
		// clearing the latch lets the flag rise at once when supply returns
		if (supplyLowSync) begin
			wdState_d = SWR_HOLD;
			wdCnt_d = '0;
			expired_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wdCnt_q <= '0;
			kickPrev_q <= 1'b0;
			expired_q <= 1'b0;
			wdState_q <= SWR_HOLD;
		end else begin
			wdCnt_q <= wdCnt_d;
			kickPrev_q <= kickPrev_d;
			expired_q <= expired_d;
			wdState_q <= wdState_d;
		end
	end

	// no stretch: direct from supply and latch
	assign timeout_flag_out_n = !(expired_q || supplyLowSync);

	// checks
	a_mr_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!mrClean |=> rstOut)
		else $error("manual reset did not assert reset");

	a_mr_debounced: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$changed(mrClean) |-> mrClean == $past(mrSync))
		else $error("filtered manual reset changed without input");

	a_supply_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
		supplyLowSync |=> rstOut && rstOut_n_oe)
		else $error("supply low did not assert reset");

	a_aux_track: assert property (@(posedge ref_clk) disable iff (!reset_n)
		aux_fail_out == $past(auxSync))
		else $error("aux fail output does not track input");

	a_wdo_supply: assert property (@(posedge ref_clk) disable iff (!reset_n)
		supplyLowSync |-> !timeout_flag_out_n)
		else $error("timeout output high while supply low");

	a_wd_supply_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		supplyLowSync |=> wdCnt_q == '0 && !expired_q)
		else $error("watchdog kept state while supply low");

	a_wdo_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(supplyLowSync) && !expired_q |-> timeout_flag_out_n)
		else $error("timeout output stretched after supply return");

	a_rst_compl: assert property (@(posedge ref_clk) disable iff (!reset_n)
		rstOut == rstOut_n_oe && !rstOut_n_o)
		else $error("reset outputs not complementary");

	a_hold_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(resetCause) |-> rstOut [*8])
		else $error("reset released without hold");

	a_hold_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(rstAct_q && !resetCause && holdCnt_q >= holdTarget - 1'b1) |=> !rstOut)
		else $error("reset held past hold time");

	a_wdo_expiry: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(wdState_q == SWR_RUN && kickDrivenSync && !wdClear && !supplyLowSync
		&& wdCnt_q >= CNT_W'(WDOG_COUNT - 1)) |=> !timeout_flag_out_n)
		else $error("watchdog period passed without timeout");

	a_wdo_latched: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(expired_q && !wdClear && kickDrivenSync && !supplyLowSync) |=> expired_q)
		else $error("timeout released without clear");

	a_kick_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(wdState_q == SWR_RUN && kickEdge && !supplyLowSync && kickDrivenSync)
		|=> wdCnt_q == '0 && !expired_q)
		else $error("kick edge did not clear watchdog");

	a_mr_wd_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!mrClean |=> wdCnt_q == '0 && !expired_q)
		else $error("manual reset did not clear watchdog");

	a_wd_disabled: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!kickDrivenSync |=> !expired_q)
		else $error("watchdog ran while kick undriven");

	a_wd_notrst: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(expired_q && !resetCause && !rstAct_q) |=> !rstOut)
		else $error("expiry asserted reset");
endmodule : swr_supervisor

//--- swr_sync.sv
module swr_sync
	import swr_pkg::*;
#(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic asyncIn,
	output logic syncOut
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = asyncIn;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign syncOut = sync_q;
endmodule : swr_sync

//--- test_supervisor_watchdog_reset.sv
module test_supervisor_watchdog_reset;
	timeunit 1ns;
	timeprecision 1ps;
	import swr_pkg::*;
	localparam int HOLD = 40;
	localparam int WD = 100;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic mrDrv = 1'b1;
	logic loopOn = 1'b0;
	logic supply_low = 1'b0;
	logic aux_monitor_in = 1'b0;
	logic kickOn = 1'b1;
	logic floatPin = 1'b0;
	logic [CNT_W-1:0] hold_delay_adjust = 32'h0;
	logic manual_reset_in_n;
	logic kick_in;
	logic kick_driven;
	logic aux_fail_out;
	logic rstOut_n_o;
	logic rstOut_n_oe;
	logic rstOut;
	logic flagN;
	int n_errors = 0;
	int n_checks = 0;
	// loop wires expiry back into manual reset
	assign manual_reset_in_n = loopOn ? flagN : mrDrv;
	swr_supervisor #(.HOLD_COUNT(HOLD), .WDOG_COUNT(WD), .DEBOUNCE_COUNT(4)) u_dut (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.manual_reset_in_n(manual_reset_in_n),
		.supply_low(supply_low),
		.aux_monitor_in(aux_monitor_in),
		.kick_in(kick_in),
		.kick_driven(kick_driven),
		.hold_delay_adjust(hold_delay_adjust),
		.aux_fail_out(aux_fail_out),
		.rstOut_n_o(rstOut_n_o),
		.rstOut_n_oe(rstOut_n_oe),
		.rstOut(rstOut),
		.timeout_flag_out_n(flagN)
	);
	swr_cpu_model u_cpu (
		.ref_clk(ref_clk),
		.rstIn(rstOut),
		.kickOn(kickOn),
		.floatPin(floatPin),
		.kick_in(kick_in),
		.kick_driven(kick_driven)
	);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic chk(input logic seen, input logic exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic give_verdict;
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic t_powerup;
		cyc(HOLD);
		chk(rstOut, 1'b1, "release early");
		chk(rstOut_n_o, 1'b0, "drain level");
		cyc(20);
		chk(rstOut, 1'b0, "reset stuck");
		chk(rstOut_n_oe, 1'b0, "drain stuck");
	endtask : t_powerup
	task automatic t_aux;
		for (int v = 1; v >= 0; v--) begin
			aux_monitor_in = v[0];
			cyc(5);
			chk(aux_fail_out, v[0], "aux out");
		end
	endtask : t_aux
	task automatic t_manual;
		mrDrv = 1'b0;
		cyc(2);
		mrDrv = 1'b1;
		cyc(10);
		chk(rstOut, 1'b0, "bounce reset");
		mrDrv = 1'b0;
		cyc(12);
		chk(rstOut, 1'b1, "no manual reset");
		chk(rstOut_n_oe, 1'b1, "drain off");
		// driving high stands in for the pull-up
		mrDrv = 1'b1;
		cyc(HOLD);
		chk(rstOut, 1'b1, "manual hold");
		cyc(20);
		chk(rstOut, 1'b0, "pulled-up pin");
	endtask : t_manual
	task automatic t_supply(input int adj);
		int h;
		h = (adj > HOLD) ? adj : HOLD;
		hold_delay_adjust = adj;
		supply_low = 1'b1;
		cyc(5);
		chk(rstOut, 1'b1, "no supply reset");
		chk(flagN, 1'b0, "flag with low supply");
		supply_low = 1'b0;
		cyc(4);
		chk(flagN, 1'b1, "flag stretched");
		cyc(h - 4);
		chk(rstOut, 1'b1, "supply hold");
		cyc(12);
		chk(rstOut, 1'b0, "hold too long");
		hold_delay_adjust = 32'h0;
	endtask : t_supply
	task automatic t_wdog;
		cyc(3 * WD);
		chk(flagN, 1'b1, "kicked expiry");
		kickOn = 1'b0;
		cyc(WD - 25);
		chk(flagN, 1'b1, "early expiry");
		cyc(40);
		chk(flagN, 1'b0, "no expiry");
		cyc(50);
		chk(flagN, 1'b0, "flag released");
		chk(rstOut, 1'b0, "expiry reset");
		kickOn = 1'b1;
		cyc(30);
		chk(flagN, 1'b1, "kick no clear");
	endtask : t_wdog
	task automatic t_float;
		floatPin = 1'b1;
		cyc(WD + 30);
		chk(flagN, 1'b1, "float expiry");
		floatPin = 1'b0;
		cyc(5);
	endtask : t_float
	task automatic t_loop;
		kickOn = 1'b0;
		loopOn = 1'b1;
		cyc(WD + 30);
		chk(rstOut, 1'b1, "looped no reset");
		chk(flagN, 1'b1, "manual no clear");
		loopOn = 1'b0;
		kickOn = 1'b1;
		cyc(HOLD + 40);
		chk(rstOut, 1'b0, "looped stuck");
	endtask : t_loop
	initial begin
		cyc(20);
		chk(rstOut, 1'b1, "power-up reset");
		reset_n = 1'b1;
		t_powerup();
		t_aux();
		t_manual();
		t_supply(0);
		t_supply(80);
		t_wdog();
		t_float();
		t_loop();
		give_verdict();
	end
	// whole run is about twelve hundred cycles
	initial begin
		#100us;
		n_errors++;
		give_verdict();
	end
endmodule : test_supervisor_watchdog_reset
